// file: tap_port.sv
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module tap_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] add_bus_line_i,
    output logic [3:0] add_bus_line_o,
    output logic [3:0] add_bus_line_oe,
    input wire logic [3:0] add_bus_line_hi,
    input wire logic add_bus_clock,
    output logic hdlc_tx_byte_clock,
    input wire logic slow_port_pos_data_i,
    output logic slow_port_pos_data_o,
    output logic slow_port_pos_data_oe,
    input wire logic slow_port_clock_i,
    output logic slow_port_clock_o,
    output logic slow_port_clock_oe,
    output logic byte_valid,
    input wire logic byte_ready,
    output logic [7:0] byte_data,
    output logic gfc_msb_marker,
    output logic gfc_serial_in,
    output logic slow_port_neg_in,
    output logic slow_port_pos_in,
    output logic slow_port_sample,
    input wire logic slow_port_neg_drop,
    input wire logic slow_port_pos_drop
);
    import tap_pkg::*;

    // ************************************************
    // pin synchronisers
    // ************************************************
    logic [7:0] pin_s1_r;
    logic [7:0] pin_s2_r;
    logic [2:0] clk_s1_r;
    logic [2:0] clk_s2_r;
    logic [2:0] clk_s3_r;
    logic [7:0] pins;
    logic [2:0] clks;
    assign pins = {add_bus_line_hi, add_bus_line_i};
    assign clks = {slow_port_pos_data_i, slow_port_clock_i, add_bus_clock};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
            clk_s1_r <= 3'h0;
            clk_s2_r <= 3'h0;
            clk_s3_r <= 3'h0;
        end else begin
            pin_s1_r <= pins;
            pin_s2_r <= pin_s1_r;
            clk_s1_r <= clks;
            clk_s2_r <= clk_s1_r;
            clk_s3_r <= clk_s2_r;
        end
    end

    // ************************************************
    // registers
    // ************************************************
    logic [31:0] ctrl_r;
    logic [1:0] drop_r;
    logic aw_got_r;
    logic w_got_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write;
    tap_role_t role;
    logic [1:0] mode;
    logic [7:0] last_byte_r;
    logic ovf_r;
    logic push;
    logic in_ready;
    assign mode = ctrl_r[TAP_CTRL_MODE_LO +: 2];
    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready = !w_got_r && !s_axi_bvalid;
    assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= TAP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_r == TAP_REG_CTRL || awaddr_r == TAP_REG_STAT) ? TAP_RESP_OKAY
                    : TAP_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= TAP_CTRL_RST;
        end else if (do_write && awaddr_r == TAP_REG_CTRL) begin
            for (int i = 0; i < 4; i++) begin
                if (wstrb_r[i]) begin
                    ctrl_r[i*8 +: 8] <= wdata_r[i*8 +: 8];
                end
            end
        end
    end
    // overflow: set beats a write-one clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_r <= 1'b0;
        end else if (push && !in_ready) begin
            ovf_r <= 1'b1;
        end else if (do_write && awaddr_r == TAP_REG_STAT && wstrb_r[0] && wdata_r[0]) begin
            ovf_r <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= TAP_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= TAP_RESP_OKAY;
                case (s_axi_araddr)
                    TAP_REG_CTRL: s_axi_rdata <= ctrl_r;
                    TAP_REG_STAT: s_axi_rdata <= {24'h000000, role, 3'h0, ovf_r};
                    TAP_REG_DATA: s_axi_rdata <= {24'h000000, last_byte_r};
                    TAP_REG_DROP: s_axi_rdata <= {28'h0000000, pin_s2_r[3:0]};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= TAP_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************
    // role selection
    // ************************************************
    always_comb begin
        if (ctrl_r[TAP_CTRL_BUS_EN]) begin
            role = TAP_ROLE_BUS;
        end else begin
            case (mode)
                TAP_MODE_HDLC: role = TAP_ROLE_HDLC;
                TAP_MODE_ATM: role = TAP_ROLE_ATM;
                TAP_MODE_MAP: role = TAP_ROLE_MAP;
                default: role = TAP_ROLE_MAP;
            endcase
        end
    end

    // ************************************************
    // byte capture (add bus and hdlc)
    // ************************************************
    logic [3:0] div_r;
    logic hclk_r;
    logic add_fall;
    logic hclk_rise;
    logic [7:0] cap_byte;
    assign add_fall = clk_s3_r[0] && !clk_s2_r[0];
    // byte clock toggles from the divider; sample taken at the same edge it rises
    assign hclk_rise = (role == TAP_ROLE_HDLC) && !hclk_r && (div_r == 4'(TAP_HDLC_DIV - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r <= 4'h0;
            hclk_r <= 1'b0;
        end else if (role != TAP_ROLE_HDLC) begin
            div_r <= 4'h0;
            hclk_r <= 1'b0;
        end else if (div_r == 4'(TAP_HDLC_DIV - 1)) begin
            div_r <= 4'h0;
            hclk_r <= ~hclk_r;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end
    assign hdlc_tx_byte_clock = hclk_r;
    // line 0 lands in bit 0 for both roles, line 3 in bit 3
    assign cap_byte = pin_s2_r;
    assign push = (role == TAP_ROLE_BUS && add_fall) || hclk_rise;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_byte_r <= 8'h00;
        end else if (push) begin
            last_byte_r <= cap_byte;
        end
    end
    // a stalled receiver leaves words in the buffer; a third one counts as overflow
    tap_buf2 #(.WIDTH(8)) u_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(push),
        .in_ready(in_ready),
        .in_data(cap_byte),
        .out_valid(byte_valid),
        .out_ready(byte_ready),
        .out_data(byte_data)
    );

    // ************************************************
    // atm and slow port
    // ************************************************
    logic ssi_rise;
    logic ssi_fall;
    logic drop;
    logic neg_r;
    logic pos_r;
    logic sclk_r;
    logic [3:0] sdiv_r;
    logic [1:0] atm_r;
    logic samp_r;
    assign drop = (role == TAP_ROLE_MAP) && ctrl_r[TAP_CTRL_DROP];
    assign ssi_rise = !clk_s3_r[1] && clk_s2_r[1];
    assign ssi_fall = drop && sclk_r && (sdiv_r == 4'(TAP_HDLC_DIV - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            atm_r <= 2'h0;
            samp_r <= 1'b0;
        end else begin
            atm_r <= (role == TAP_ROLE_ATM) ? {pin_s2_r[0], pin_s2_r[1]} : 2'h0;
            samp_r <= (role == TAP_ROLE_MAP) && !drop && ssi_rise;
        end
    end
    // line 1 is ignored in mapper mode, it is read as gfc data in atm mode and as byte bit 1 in the add-bus and hdlc roles
    assign gfc_msb_marker = atm_r[1];
    assign gfc_serial_in = atm_r[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sdiv_r <= 4'h0;
            sclk_r <= 1'b0;
        end else if (!drop) begin
            sdiv_r <= 4'h0;
            sclk_r <= 1'b0;
        end else if (sdiv_r == 4'(TAP_HDLC_DIV - 1)) begin
            sdiv_r <= 4'h0;
            sclk_r <= ~sclk_r;
        end else begin
            sdiv_r <= sdiv_r + 4'h1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            neg_r <= 1'b0;
            pos_r <= 1'b0;
        end else if (ssi_fall) begin
            neg_r <= slow_port_neg_drop;
            pos_r <= slow_port_pos_drop;
        end else if ((role == TAP_ROLE_MAP) && !drop && ssi_rise) begin
            neg_r <= pin_s2_r[3];
            pos_r <= clk_s2_r[2];
        end
    end
    assign slow_port_neg_in = neg_r;
    assign slow_port_pos_in = pos_r;
    assign slow_port_sample = samp_r;

    // ************************************************
    // pin drive
    // ************************************************
    always_comb begin
        add_bus_line_o = 4'h0;
        add_bus_line_oe = 4'h0;
        if (role == TAP_ROLE_ATM) begin
            add_bus_line_o[2] = ctrl_r[TAP_CTRL_CELL];
            add_bus_line_oe[2] = 1'b1;
        end
        if (drop) begin
            add_bus_line_o[3] = neg_r;
            add_bus_line_oe[3] = 1'b1;
        end
    end
    assign slow_port_pos_data_o = pos_r;
    assign slow_port_pos_data_oe = drop;
    assign slow_port_clock_o = sclk_r;
    assign slow_port_clock_oe = drop;
endmodule

// file: tap_pkg.sv
// Contract
// - with the add bus enabled, capture the add byte on each falling add clock edge.
// - bus enable picks the add-bus role; otherwise mode picks HDLC, ATM or mapper.
// - HDLC mode drives a byte clock out and samples the byte on its rise.
// - in HDLC mode line 0 is byte bit 0 and line 3 is bit 3.
// - ATM mode uses line 0 GFC msb, line 1 GFC data, line 2 cell sent.
// - mapper mode uses line 3 as slow-port negative data, add or drop selected.
// - slow-port add samples negative data on the rising slow-port clock edge.
// - slow-port drop drives negative data, updated on the falling slow-port clock edge.
package tap_pkg;
    typedef enum logic [3:0] {
        TAP_ROLE_BUS = 4'h1,
        TAP_ROLE_HDLC = 4'h2,
        TAP_ROLE_ATM = 4'h4,
        TAP_ROLE_MAP = 4'h8
    } tap_role_t;
    localparam logic [1:0] TAP_MODE_HDLC = 2'h0;
    localparam logic [1:0] TAP_MODE_ATM = 2'h1;
    localparam logic [1:0] TAP_MODE_MAP = 2'h2;
    localparam logic [11:0] TAP_REG_CTRL = 12'h000;
    localparam logic [11:0] TAP_REG_STAT = 12'h004;
    localparam logic [11:0] TAP_REG_DATA = 12'h008;
    localparam logic [11:0] TAP_REG_DROP = 12'h00C;
    localparam int TAP_CTRL_BUS_EN = 0;
    localparam int TAP_CTRL_MODE_LO = 1;
    localparam int TAP_CTRL_DROP = 3;
    localparam int TAP_CTRL_CELL = 4;
    localparam int TAP_HDLC_DIV = 4;
    localparam logic [31:0] TAP_CTRL_RST = 32'h0000_0000;
    localparam logic [1:0] TAP_RESP_OKAY = 2'h0;
    localparam logic [1:0] TAP_RESP_SLVERR = 2'h2;
    localparam int TAP_SYNC_DEPTH = 2;
endpackage

// file: tap_buf2.sv
`timescale 1ns/1ps
module tap_buf2 #(
    parameter int WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_r [2];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    logic push;
    logic pop;
    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge aclk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule

// file: tap_port_checker.sv
`timescale 1ns/1ps
// ****
// pin role checks
// ****
module tap_port_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] add_bus_line_o,
    input wire logic [3:0] add_bus_line_oe,
    input wire logic hdlc_tx_byte_clock,
    input wire logic slow_port_clock_o,
    input wire logic slow_port_clock_oe,
    input wire logic byte_valid,
    input wire logic byte_ready,
    input wire logic [7:0] byte_data,
    input wire logic gfc_msb_marker,
    input wire logic gfc_serial_in,
    input wire logic slow_port_sample
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    in_only_a: assert property (add_bus_line_oe[1:0] == 2'h0)
        else $error("input line driven");
    one_role_a: assert property (!(add_bus_line_oe[2] && add_bus_line_oe[3]))
        else $error("two output roles at once");
    drop_pins_a: assert property (add_bus_line_oe[3] == slow_port_clock_oe)
        else $error("drop line and clock enables differ");
    drop_edge_a: assert property ($past(add_bus_line_oe[3]) && add_bus_line_oe[3]
        && $changed(add_bus_line_o[3]) |-> !slow_port_clock_o) else $error("drop line moved with clock high");
    byte_clk_a: assert property ($fell(hdlc_tx_byte_clock) |-> !hdlc_tx_byte_clock [*4])
        else $error("byte clock low phase short");
    gfc_idle_a: assert property (add_bus_line_oe[3] |=> !gfc_msb_marker && !gfc_serial_in)
        else $error("cell lines active in drop role");
    sample_pulse_a: assert property (slow_port_sample |=> !slow_port_sample)
        else $error("sample pulse too long");
    byte_hold_a: assert property (byte_valid && !byte_ready |=> byte_valid && $stable(byte_data))
        else $error("stalled byte lost");
endmodule
bind tap_port tap_port_checker chk (.*);

// file: tap_far_model.sv
`timescale 1ns/1ps
// ****
// system-side source of the add lines and slow port
// ****
module tap_far_model (
    input wire logic aclk,
    input wire logic [3:0] add_bus_line_o,
    input wire logic [3:0] add_bus_line_oe,
    output logic [3:0] add_bus_line_i,
    output logic [3:0] add_bus_line_hi,
    output logic add_bus_clock,
    input wire logic slow_port_pos_data_o,
    input wire logic slow_port_pos_data_oe,
    output logic slow_port_pos_data_i,
    input wire logic slow_port_clock_o,
    input wire logic slow_port_clock_oe,
    output logic slow_port_clock_i
);
    logic [7:0] drv_r = 8'h00;
    logic clk_r = 1'h0;
    logic pos_r = 1'h0;
    logic clk_a_r = 1'h1;
    // a line the device drives reads back its level, not ours
    assign add_bus_line_i = (add_bus_line_oe & add_bus_line_o) | (~add_bus_line_oe & drv_r[3:0]);
    assign add_bus_line_hi = drv_r[7:4];
    assign slow_port_clock_i = slow_port_clock_oe ? slow_port_clock_o : clk_r;
    assign slow_port_pos_data_i = slow_port_pos_data_oe ? slow_port_pos_data_o : pos_r;
    assign add_bus_clock = clk_a_r;
    // clock idles high; data is inverted once its hold has run out
    task automatic add_byte(input logic [7:0] b);
        drv_r <= b;
        repeat (2) @(posedge aclk);
        clk_a_r <= 1'h0;
        repeat (4) @(posedge aclk);
        clk_a_r <= 1'h1;
        @(posedge aclk);
        drv_r <= ~b;
        @(posedge aclk);
    endtask
    task automatic ssi_add(input logic n, input logic p);
        drv_r <= {4'h0, n, 3'h0};
        pos_r <= p;
        repeat (2) @(posedge aclk);
        clk_r <= 1'h1;
        repeat (4) @(posedge aclk);
        clk_r <= 1'h0;
        @(posedge aclk);
        drv_r <= {4'h0, !n, 3'h0};
        pos_r <= !p;
        // low phase closes with the next call's lead-in, keeping the slow clock at 400 ns
        @(posedge aclk);
    endtask
endmodule

// file: tap_port_tb.sv
`timescale 1ns/1ps
// ****
// register, stream and pin role tests
// ****
module tap_port_tb;
    import tap_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, byte_valid, add_bus_clock;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] add_bus_line_i, add_bus_line_o, add_bus_line_oe, add_bus_line_hi;
    logic [7:0] byte_data;
    logic hdlc_tx_byte_clock, gfc_msb_marker, gfc_serial_in, slow_port_neg_in, slow_port_pos_in, slow_port_sample;
    logic slow_port_pos_data_i, slow_port_pos_data_o, slow_port_pos_data_oe;
    logic slow_port_clock_i, slow_port_clock_o, slow_port_clock_oe;
    logic byte_ready = 1'h0, slow_port_neg_drop = 1'h0, slow_port_pos_drop = 1'h0;
    logic [31:0] ctl [6] = '{32'h1, 32'h0, 32'h2, 32'h4, 32'h6, 32'h3};
    logic [3:0] role [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h8, 4'h1};
    int errors = 0;
    int n_tests = 0;
    int n_samp = 0;
    int n_hrise = 0;
    int k = 0;
    logic hclk_q = 1'h0;
    always #25 aclk = ~aclk;
    // pulse-type outputs are counted here and the counts compared in the tests
    always @(posedge aclk) begin
        hclk_q <= hdlc_tx_byte_clock;
        if (hdlc_tx_byte_clock && !hclk_q) n_hrise <= n_hrise + 1;
        if (slow_port_sample) n_samp <= n_samp + 1;
    end
    tap_port dut (.*);
    tap_far_model far (.*);
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cb(input logic g, input logic e);
        cmp({31'h0, g}, {31'h0, e});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = TAP_RESP_OKAY);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        // bready stays up between writes, so back-to-back calls never drop and raise it in one step
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        cmp({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] ed,
                      input logic [1:0] er = TAP_RESP_OKAY);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        cmp({30'h0, s_axi_rresp}, {30'h0, er});
        cmp(s_axi_rdata & m, ed);
    endtask
    // a byte is looked at while it waits, then taken on the next edge
    task automatic take(input logic [7:0] e);
        repeat (40) begin
            @(posedge aclk);
            if (byte_valid) break;
        end
        cmp({24'h0, byte_data}, {24'h0, e});
        byte_ready <= 1'h1;
        @(posedge aclk);
        byte_ready <= 1'h0;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        wrap_up;
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(TAP_REG_CTRL, 32'hFFFF_FFFF, TAP_CTRL_RST);
        rd(TAP_REG_STAT, 32'hF0, 32'h20);
        rd(12'h010, 32'hFFFF_FFFF, 32'h0, TAP_RESP_SLVERR);
        wr(12'h010, 32'h1, TAP_RESP_SLVERR);
        for (int i = 0; i < 6; i++) begin
            wr(TAP_REG_CTRL, ctl[i]);
            rd(TAP_REG_STAT, 32'hF0, {24'h0, role[i], 4'h0});
        end
        // the reset mode already streams bytes, so flush them first
        wr(TAP_REG_CTRL, 32'h1);
        byte_ready <= 1'h1;
        repeat (4) @(posedge aclk);
        byte_ready <= 1'h0;
        wr(TAP_REG_STAT, 32'h1);
        far.add_byte(8'h1E);
        take(8'h1E);
        rd(TAP_REG_DATA, 32'hFF, 32'h1E);
        far.add_byte(8'h21);
        far.add_byte(8'h42);
        far.add_byte(8'h84);
        rd(TAP_REG_STAT, 32'h1, 32'h1);
        take(8'h21);
        take(8'h42);
        repeat (20) @(posedge aclk);
        cb(byte_valid, 1'h0);
        wr(TAP_REG_STAT, 32'h1);
        rd(TAP_REG_STAT, 32'h1, 32'h0);
        far.drv_r <= 8'h6B;
        k = n_hrise;
        wr(TAP_REG_CTRL, 32'h0);
        repeat (32) @(posedge aclk);
        cmp(32'(n_hrise - k), 32'h4);
        rd(TAP_REG_DATA, 32'hFF, 32'h6B);
        take(8'h6B);
        far.drv_r <= 8'h01;
        wr(TAP_REG_CTRL, 32'h12);
        repeat (8) @(posedge aclk);
        cb(gfc_msb_marker, 1'h1);
        cb(gfc_serial_in, 1'h0);
        cb(add_bus_line_i[2], 1'h1);
        rd(TAP_REG_DROP, 32'hF, 32'h5);
        cmp({28'h0, add_bus_line_oe}, 32'h4);
        cb(hdlc_tx_byte_clock, 1'h0);
        far.drv_r <= 8'h02;
        wr(TAP_REG_CTRL, 32'h2);
        repeat (8) @(posedge aclk);
        cb(gfc_serial_in, 1'h1);
        cb(add_bus_line_i[2], 1'h0);
        far.drv_r <= 8'h00;
        wr(TAP_REG_CTRL, 32'h4);
        cmp({28'h0, add_bus_line_oe}, 32'h0);
        for (int i = 0; i < 2; i++) begin
            far.ssi_add(i[0], !i[0]);
            cb(slow_port_neg_in, i[0]);
            cb(slow_port_pos_in, !i[0]);
        end
        cmp(32'(n_samp), 32'h2);
        slow_port_neg_drop <= 1'h1;
        slow_port_pos_drop <= 1'h1;
        wr(TAP_REG_CTRL, 32'hC);
        repeat (20) @(posedge aclk);
        cmp({28'h0, add_bus_line_oe}, 32'h8);
        cb(add_bus_line_i[3], 1'h1);
        cb(slow_port_pos_data_i, 1'h1);
        slow_port_neg_drop <= 1'h0;
        repeat (20) @(posedge aclk);
        cb(add_bus_line_i[3], 1'h0);
        wrap_up;
    end
endmodule
